/* File: logic/touch_ctrl_pkg.sv */
// Purpose: Shared constants and types for the touch digitizer control word decoder
// Assumes: One control word of eight bits, start bit first
// Notes: Field positions, counts and reset values are defined here; the checks and the bench also repeat some as literals
package touch_ctrl_pkg;

    localparam int WORD_BITS = 8;
    localparam int START_POS = 7;
    localparam int CHAN_HI_POS = 6;
    localparam int CHAN_LO_POS = 4;
    localparam int MODE_POS = 3;
    localparam int REF_POS = 2;
    localparam int PD_HI_POS = 1;
    localparam int PD_LO_POS = 0;

    localparam logic [7:0] WORD_RESET = 8'h00;

    // Channel codes of the channel_select_field
    localparam logic [2:0] CHAN_XPLUS = 3'h1;
    localparam logic [2:0] CHAN_IN3 = 3'h2;
    localparam logic [2:0] CHAN_YPLUS = 3'h5;
    localparam logic [2:0] CHAN_IN4 = 3'h6;

    // Multiplexer selections driven to the analog front end
    localparam logic [2:0] MUX_NONE = 3'h0;
    localparam logic [2:0] MUX_XPLUS = 3'h1;
    localparam logic [2:0] MUX_IN3 = 3'h2;
    localparam logic [2:0] MUX_YPLUS = 3'h3;
    localparam logic [2:0] MUX_IN4 = 3'h4;

    // Link cycle counts
    localparam logic [3:0] HOLD_12BIT = 4'h7;
    localparam logic [3:0] HOLD_8BIT = 4'h3;
    localparam logic [3:0] LAST_BIT_COUNT = 4'h7;
    localparam logic [4:0] ACQ_CYCLES = 5'h03;
    localparam logic [4:0] CONV_12BIT = 5'h0C;
    localparam logic [4:0] CONV_8BIT = 5'h08;

    typedef enum logic [2:0] {
        LINK_HUNT = 3'b001,
        LINK_SHIFT = 3'b010,
        LINK_HOLD = 3'b100
    } link_state_t;

    typedef struct packed {
        logic [2:0] muxInput;
        logic xDriversOn;
        logic yDriversOn;
        logic yMinusOn;
        logic refFromDrivers;
        logic powerUp;
        logic touchIrqEnable;
        logic eightBitMode;
    } analog_ctrl_t;

endpackage

/* File: logic/level_sync3.sv */
// Purpose: Three-stage level synchroniser with agreement filter
// Assumes: Inputs are levels that stay put for several destination cycles
// Notes: The first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module level_sync3 #(
    parameter int WIDTH = 1
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst,
    // Levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] s1_q, s2_q, s3_q, filt_q;
    logic [WIDTH-1:0] filt_d;

    generate
        if (WIDTH < 1) begin : g_bad
            $error("level_sync3 needs WIDTH of at least one");
        end
    endgenerate

    // A change counts only once stages two and three agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            filt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : filt_q[i];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            filt_q <= '0;
        end else begin
            s1_q <= asyncIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            filt_q <= filt_d;
        end
    end

    assign syncOut = filt_q;

endmodule
`default_nettype wire

/* File: logic/touch_setting_decoder.sv */
// Purpose: Turns a stored control word into analog front end settings
// Assumes: Word fields as laid out in the package
// Notes: Purely combinational; the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module touch_setting_decoder
    import touch_ctrl_pkg::*;
(
    // Stored word and conversion activity
    input wire logic [7:0] controlWord,
    input wire logic converting,
    // Decoded settings
    output analog_ctrl_t settings
);

    logic [2:0] channelSelectField;
    logic referenceKindSelect;
    logic powerFieldHigh;
    logic powerFieldLow;
    logic driversActive;
    logic powered;

    always_comb begin
        channelSelectField = controlWord[CHAN_HI_POS:CHAN_LO_POS];
        referenceKindSelect = controlWord[REF_POS];
        powerFieldHigh = controlWord[PD_HI_POS];
        powerFieldLow = controlWord[PD_LO_POS];
        // Power-up is instant, so conversion activity alone wakes the part
        powered = converting | powerFieldHigh;
        // Drivers also stay on with power field 11, which stays powered with the pen interrupt off
        driversActive = converting | (powerFieldHigh & powerFieldLow);
        settings = '0;
        case (channelSelectField)
            CHAN_XPLUS: begin
                settings.muxInput = MUX_XPLUS;
                settings.yDriversOn = driversActive;
            end
            CHAN_IN3: begin
                settings.muxInput = MUX_IN3;
            end
            CHAN_YPLUS: begin
                settings.muxInput = MUX_YPLUS;
                settings.xDriversOn = driversActive;
            end
            CHAN_IN4: begin
                settings.muxInput = MUX_IN4;
            end
            default: begin
                settings.muxInput = MUX_NONE;
            end
        endcase
        // Only touch channels can reference from the drivers
        settings.refFromDrivers = ~referenceKindSelect & ((channelSelectField == CHAN_XPLUS) |
            (channelSelectField == CHAN_YPLUS));
        settings.yMinusOn = settings.yDriversOn |
            (~powered & ~powerFieldHigh & ~powerFieldLow);
        settings.powerUp = powered;
        settings.touchIrqEnable = ~powerFieldLow;
        settings.eightBitMode = controlWord[MODE_POS];
    end

endmodule
`default_nettype wire

/* File: logic/touch_adc_control_word_decoder.sv */
// Purpose: Serial control word capture and decode for a touch screen digitizer
// Assumes: Serial bits are valid at rising conversion_clock edges
// Notes: The link clock may stop between frames; settings hold meanwhile
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Serial input is ignored until a high start bit, which becomes word bit 7.
// - Channel bits with reference bit choose multiplexer, drivers and reference.
// - Mode bit zero means 12-bit conversion, one means 8-bit.
// - Reference bit one is single-ended, zero is differential.
// - Single-ended uses reference pin and ground; differential uses driver nodes.
// - Next start accepted after 15 cycles in 12-bit, 11 in 8-bit.
// - Bits 1 and 0 decode four power and pen interrupt behaviours.
// - Power field 00 powers down after conversion, pen interrupt enabled.
// - Leaving power-down is instant at conversion start.
// - Power field 00 keeps Y-minus switch closed during power-down.
// - Power field 01 like 00 but interrupt off and Y-minus open.
// - Power field 10 stays powered with pen interrupt enabled.
// - Power field 11 stays powered with pen interrupt disabled.
// - Word bits arrive on eight rising edges, most significant first.
// - Channel 001 turns on Y drivers, channel 101 turns on X drivers.
module touch_adc_control_word_decoder
    import touch_ctrl_pkg::*;
(
    // Core clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial link
    input wire logic conversion_clock,
    input wire logic serialDataIn,
    // Pen contact sense from the analog side
    input wire logic penTouched,
    // Analog control and interrupt
    output analog_ctrl_t analogCtrl,
    output logic touchIrqOutN,
    output logic conversionActive
);

    // Link domain state
    link_state_t linkState_q, linkState_d;
    logic [3:0] bitCount_q, bitCount_d;
    logic [3:0] holdCount_q, holdCount_d;
    logic [6:0] shift_q, shift_d;
    logic [7:0] wordLink_q, wordLink_d;
    logic [4:0] convCount_q, convCount_d;
    logic converting_q, converting_d;
    logic pending_q, pending_d;
    logic [7:0] xferWord_q, xferWord_d;
    logic reqToggle_q, reqToggle_d;
    logic ackLink;
    logic wordDone;
    logic launch;
    logic [7:0] newWord;

    // Core domain state
    logic [7:0] conversion_control_word_q, conversion_control_word_d;
    logic ackToggle_q, ackToggle_d;
    analog_ctrl_t analogCtrl_q;
    analog_ctrl_t decoded;
    logic irqN_q, irqN_d;
    logic reqSync, convSync, penSync;

    assign newWord = {shift_q, serialDataIn};
    assign wordDone = (linkState_q == LINK_SHIFT) && (bitCount_q == LAST_BIT_COUNT);
    assign launch = pending_q && (reqToggle_q == ackLink);

    always_comb begin
        linkState_d = linkState_q;
        bitCount_d = bitCount_q;
        holdCount_d = holdCount_q;
        shift_d = shift_q;
        wordLink_d = wordLink_q;
        case (linkState_q)
            LINK_HUNT: begin
                if (serialDataIn) begin
                    linkState_d = LINK_SHIFT;
                    bitCount_d = 4'h1;
                    shift_d = 7'h01;
                end
            end
            LINK_SHIFT: begin
                shift_d = newWord[6:0];
                bitCount_d = bitCount_q + 4'h1;
                if (wordDone) begin
                    wordLink_d = newWord;
                    linkState_d = LINK_HOLD;
                    // Lockout sets the least start-to-start spacing
                    holdCount_d = newWord[MODE_POS] ? HOLD_8BIT : HOLD_12BIT;
                end
            end
            LINK_HOLD: begin
                holdCount_d = holdCount_q - 4'h1;
                if (holdCount_q == 4'h1) begin
                    linkState_d = LINK_HUNT;
                end
            end
            default: begin
                linkState_d = LINK_HUNT;
            end
        endcase
    end

    always_comb begin
        convCount_d = (convCount_q != 5'h00) ? convCount_q - 5'h01 : 5'h00;
        if (wordDone) begin
            convCount_d = ACQ_CYCLES + (newWord[MODE_POS] ? CONV_8BIT : CONV_12BIT);
        end
        converting_d = (convCount_d != 5'h00);
        // A word finishing during a launch keeps pending set
        pending_d = (pending_q & ~launch) | wordDone;
        xferWord_d = launch ? wordLink_q : xferWord_q;
        reqToggle_d = launch ? ~reqToggle_q : reqToggle_q;
    end

    always_ff @(posedge conversion_clock or posedge rst) begin
        if (rst) begin
            linkState_q <= LINK_HUNT;
            bitCount_q <= 4'h0;
            holdCount_q <= 4'h0;
            shift_q <= 7'h00;
            wordLink_q <= WORD_RESET;
            convCount_q <= 5'h00;
            converting_q <= 1'b0;
            pending_q <= 1'b0;
            xferWord_q <= WORD_RESET;
            reqToggle_q <= 1'b0;
        end else begin
            linkState_q <= linkState_d;
            bitCount_q <= bitCount_d;
            holdCount_q <= holdCount_d;
            shift_q <= shift_d;
            wordLink_q <= wordLink_d;
            convCount_q <= convCount_d;
            converting_q <= converting_d;
            pending_q <= pending_d;
            xferWord_q <= xferWord_d;
            reqToggle_q <= reqToggle_d;
        end
    end

    // Acknowledge back to the link; xferWord_q is frozen until it returns
    level_sync3 #(.WIDTH(1)) u_ackSync (
        .clk(conversion_clock),
        .rst(rst),
        .asyncIn(ackToggle_q),
        .syncOut(ackLink)
    );

    level_sync3 #(.WIDTH(3)) u_coreSync (
        .clk(core_clk),
        .rst(rst),
        .asyncIn({reqToggle_q, converting_q, penTouched}),
        .syncOut({reqSync, convSync, penSync})
    );

    touch_setting_decoder u_decoder (
        .controlWord(conversion_control_word_q),
        .converting(convSync),
        .settings(decoded)
    );

    always_comb begin
        conversion_control_word_d = conversion_control_word_q;
        ackToggle_d = ackToggle_q;
        if (reqSync != ackToggle_q) begin
            conversion_control_word_d = xferWord_q;
            ackToggle_d = ~ackToggle_q;
        end
        irqN_d = ~(penSync & decoded.touchIrqEnable);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conversion_control_word_q <= WORD_RESET;
            ackToggle_q <= 1'b0;
            analogCtrl_q <= '0;
            irqN_q <= 1'b1;
        end else begin
            conversion_control_word_q <= conversion_control_word_d;
            ackToggle_q <= ackToggle_d;
            analogCtrl_q <= decoded;
            irqN_q <= irqN_d;
        end
    end

    assign analogCtrl = analogCtrl_q;
    assign touchIrqOutN = irqN_q;
    assign conversionActive = convSync;

    // Link domain checks
    AST_IGNORE_LOW: assert property (@(posedge conversion_clock) disable iff (rst)
        (linkState_q == LINK_HUNT) && !serialDataIn |=> (linkState_q == LINK_HUNT))
        else $error("Low input left the hunt state");
    AST_START_FIRST: assert property (@(posedge conversion_clock) disable iff (rst)
        wordDone |=> wordLink_q[START_POS])
        else $error("Captured word lacks its start bit");
    AST_EIGHT_EDGES: assert property (@(posedge conversion_clock) disable iff (rst)
        (linkState_q == LINK_HUNT) && serialDataIn |-> ##7 wordDone)
        else $error("Word not complete on the eighth edge");
    AST_LOCK_12: assert property (@(posedge conversion_clock) disable iff (rst)
        wordDone && !newWord[MODE_POS] |=> (linkState_q == LINK_HOLD) [*7]
        ##1 (linkState_q == LINK_HUNT))
        else $error("Wrong lockout after 12-bit word");
    AST_LOCK_8: assert property (@(posedge conversion_clock) disable iff (rst)
        wordDone && newWord[MODE_POS] |=> (linkState_q == LINK_HOLD) [*3]
        ##1 (linkState_q == LINK_HUNT))
        else $error("Wrong lockout after 8-bit word");
    AST_HUNT_START: assert property (@(posedge conversion_clock) disable iff (rst)
        (linkState_q == LINK_HUNT) && serialDataIn |=> (linkState_q == LINK_SHIFT))
        else $error("Start bit not taken");
    AST_SHIFT_STAYS: assert property (@(posedge conversion_clock) disable iff (rst)
        (linkState_q == LINK_SHIFT) && !wordDone |=> (linkState_q == LINK_SHIFT))
        else $error("Shift ended before eight bits");
    AST_HOLD_IGNORES: assert property (@(posedge conversion_clock) disable iff (rst)
        (linkState_q == LINK_HOLD) && (holdCount_q != 4'h1) |=> (linkState_q == LINK_HOLD))
        else $error("Start accepted inside the lockout");
    AST_CONV_STARTS: assert property (@(posedge conversion_clock) disable iff (rst)
        wordDone |=> converting_q)
        else $error("Conversion not started by a word");
    AST_CONV_ENDS: assert property (@(posedge conversion_clock) disable iff (rst)
        (convCount_q == 5'h01) && !wordDone |=> !converting_q)
        else $error("Conversion activity outlived its count");
    AST_WORD_PENDING: assert property (@(posedge conversion_clock) disable iff (rst)
        wordDone |=> pending_q)
        else $error("Finished word not queued for the core");

    // Core domain checks
    AST_ALWAYS_ON: assert property (@(posedge core_clk) disable iff (rst)
        conversion_control_word_q[PD_HI_POS] |=> analogCtrl_q.powerUp)
        else $error("Power field high bit did not keep power on");
    AST_WAKE: assert property (@(posedge core_clk) disable iff (rst)
        convSync |=> analogCtrl_q.powerUp)
        else $error("Not powered during conversion");
    AST_YMINUS_CLOSED: assert property (@(posedge core_clk) disable iff (rst)
        conversion_control_word_q[1:0] == 2'h0 && !convSync |=> analogCtrl_q.yMinusOn)
        else $error("Y-minus open in power-down with field 00");
    AST_YMINUS_OPEN: assert property (@(posedge core_clk) disable iff (rst)
        conversion_control_word_q[1:0] == 2'h1 && !convSync |=> !analogCtrl_q.yMinusOn)
        else $error("Y-minus closed in power-down with field 01");
    AST_IRQ_MASKED: assert property (@(posedge core_clk) disable iff (rst)
        conversion_control_word_q[PD_LO_POS] |=> touchIrqOutN)
        else $error("Pen interrupt asserted while disabled");
    AST_Y_DRIVERS: assert property (@(posedge core_clk) disable iff (rst)
        conversion_control_word_q[6:4] == CHAN_XPLUS && convSync |=> analogCtrl_q.yDriversOn)
        else $error("Y drivers off for channel 001");
    AST_WORD_HELD: assert property (@(posedge core_clk) disable iff (rst)
        reqSync == ackToggle_q |=> $stable(conversion_control_word_q))
        else $error("Settings changed without a new word");
    AST_WORD_TAKEN: assert property (@(posedge core_clk) disable iff (rst)
        reqSync != ackToggle_q |=> (conversion_control_word_q == $past(xferWord_q)))
        else $error("Handed word not stored");

    // Field decode checks; drivers and power also follow the synchronised activity
    logic [2:0] storedChan;
    assign storedChan = conversion_control_word_q[CHAN_HI_POS:CHAN_LO_POS];
    AST_MODE_REG: assert property (@(posedge core_clk) disable iff (rst)
        1'b1 |=> (analogCtrl_q.eightBitMode == $past(conversion_control_word_q[MODE_POS])))
        else $error("Resolution does not follow the mode bit");
    AST_REF_SINGLE: assert property (@(posedge core_clk) disable iff (rst)
        conversion_control_word_q[REF_POS] |=> !analogCtrl_q.refFromDrivers)
        else $error("Single-ended word referenced from drivers");
    AST_REF_DIFF: assert property (@(posedge core_clk) disable iff (rst)
        !conversion_control_word_q[REF_POS] && (storedChan == CHAN_XPLUS)
        |=> analogCtrl_q.refFromDrivers)
        else $error("Differential word not referenced from drivers");
    AST_X_DRIVERS: assert property (@(posedge core_clk) disable iff (rst)
        (storedChan == CHAN_YPLUS) && convSync |=> analogCtrl_q.xDriversOn)
        else $error("X drivers off for channel 101");
    AST_Y_WITH_MINUS: assert property (@(posedge core_clk) disable iff (rst)
        analogCtrl_q.yDriversOn |-> analogCtrl_q.yMinusOn)
        else $error("Y drivers on without the Y-minus switch");
    AST_IRQ_ENABLED: assert property (@(posedge core_clk) disable iff (rst)
        !conversion_control_word_q[PD_LO_POS] |=> analogCtrl_q.touchIrqEnable)
        else $error("Pen interrupt not enabled");
    AST_POWER_DOWN: assert property (@(posedge core_clk) disable iff (rst)
        !conversion_control_word_q[PD_HI_POS] && !convSync |=> !analogCtrl_q.powerUp)
        else $error("Powered while idle with power-down selected");
    AST_NO_PEN: assert property (@(posedge core_clk) disable iff (rst)
        !penSync |=> touchIrqOutN)
        else $error("Pen interrupt without contact");
    AST_MUX_X: assert property (@(posedge core_clk) disable iff (rst)
        (storedChan == CHAN_XPLUS) |=> (analogCtrl_q.muxInput == MUX_XPLUS))
        else $error("Wrong input for channel 001");
    AST_MUX_Y: assert property (@(posedge core_clk) disable iff (rst)
        (storedChan == CHAN_YPLUS) |=> (analogCtrl_q.muxInput == MUX_YPLUS))
        else $error("Wrong input for channel 101");
    AST_MUX_IN3: assert property (@(posedge core_clk) disable iff (rst)
        (storedChan == CHAN_IN3) |=> (analogCtrl_q.muxInput == MUX_IN3) &&
        !analogCtrl_q.xDriversOn && !analogCtrl_q.yDriversOn)
        else $error("Wrong setting for auxiliary input three");
    AST_MUX_IN4: assert property (@(posedge core_clk) disable iff (rst)
        (storedChan == CHAN_IN4) |=> (analogCtrl_q.muxInput == MUX_IN4))
        else $error("Wrong input for auxiliary input four");

    COV_WORD_12: cover property (@(posedge conversion_clock) disable iff (rst)
        wordDone && !newWord[MODE_POS]);
    COV_WORD_8: cover property (@(posedge conversion_clock) disable iff (rst)
        wordDone && newWord[MODE_POS]);
    COV_BACK_TO_BACK: cover property (@(posedge conversion_clock) disable iff (rst)
        wordDone ##8 (linkState_q == LINK_HUNT) && serialDataIn);
    COV_WORD_TAKEN: cover property (@(posedge core_clk) disable iff (rst)
        reqSync != ackToggle_q);
    COV_PEN_IRQ: cover property (@(posedge core_clk) disable iff (rst)
        !touchIrqOutN);

endmodule
`default_nettype wire

/* File: bench/host_serial_model.sv */
// Purpose: Host serial port that shifts control words into the decoder
// Assumes: Link clock stands still between frames
// Notes: Idle data shows the inverse of its last bit, so a stale value never passes
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
    // Serial link
    output logic conversion_clock,
    output logic serialDataIn
);
    initial begin
        conversion_clock = 1'b0;
        serialDataIn = 1'b0;
    end
    task automatic clock_bit(input logic b);
        serialDataIn = b;
        #6 conversion_clock = 1'b1;
        #6 conversion_clock = 1'b0;
    endtask
    // Lead zeros, word msb first, then idle edges; ones during the lockout as a decoy
    task automatic send_word(input logic [7:0] w, input int lead, input int idle);
        int lock;
        lock = w[3] ? 3 : 7;
        #5.3;
        for (int i = 0; i < lead; i++) clock_bit(1'b0);
        for (int i = 7; i >= 0; i--) clock_bit(w[i]);
        for (int i = 0; i < idle; i++) clock_bit(i < lock);
        serialDataIn = ~serialDataIn;
    endtask
endmodule
`default_nettype wire

/* File: bench/test_touch_adc_control_word_decoder.sv */
// Purpose: Self-checking bench for the control word decoder
// Assumes: Full idle settings are compared once the link clock has stopped
// Notes: Consecutive words always differ in a watched field, so each change marks one word
`timescale 1ns/1ps
`default_nettype none
module test_touch_adc_control_word_decoder;
    import touch_ctrl_pkg::*;
    logic core_clk;
    logic rst;
    logic penTouched;
    logic conversion_clock;
    logic serialDataIn;
    logic touchIrqOutN;
    logic conversionActive;
    analog_ctrl_t analogCtrl;
    logic [7:0] noteQ[$];
    logic [5:0] prevStatic;
    logic watch;
    logic [7:0] w;
    logic [7:0] w2;
    int errors;
    int num_checks;
    int seed;
    // Valid channel and reference pairs; differential only for X and Y position
    logic [2:0] chanTab[6] = '{3'h1, 3'h2, 3'h5, 3'h6, 3'h1, 3'h5};
    logic refTab[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    touch_adc_control_word_decoder i_touch_adc_control_word_decoder (
        .core_clk(core_clk),
        .rst(rst),
        .conversion_clock(conversion_clock),
        .serialDataIn(serialDataIn),
        .penTouched(penTouched),
        .analogCtrl(analogCtrl),
        .touchIrqOutN(touchIrqOutN),
        .conversionActive(conversionActive)
    );

    host_serial_model i_host_serial_model (
        .conversion_clock(conversion_clock),
        .serialDataIn(serialDataIn)
    );

    // Idle settings once conversion is over
    function automatic analog_ctrl_t settle_ctrl(input logic [7:0] cw);
        analog_ctrl_t e;
        logic [2:0] ch;
        logic [1:0] pd;
        ch = cw[6:4];
        pd = cw[1:0];
        case (ch)
            CHAN_XPLUS: e.muxInput = MUX_XPLUS;
            CHAN_IN3: e.muxInput = MUX_IN3;
            CHAN_YPLUS: e.muxInput = MUX_YPLUS;
            CHAN_IN4: e.muxInput = MUX_IN4;
            default: e.muxInput = MUX_NONE;
        endcase
        e.xDriversOn = (pd == 2'h3) && (ch == CHAN_YPLUS);
        e.yDriversOn = (pd == 2'h3) && (ch == CHAN_XPLUS);
        e.yMinusOn = e.yDriversOn || (pd == 2'h0);
        e.refFromDrivers = !cw[2] && (ch == CHAN_XPLUS || ch == CHAN_YPLUS);
        e.powerUp = pd[1];
        e.touchIrqEnable = !pd[0];
        e.eightBitMode = cw[3];
        return e;
    endfunction

    function automatic logic [5:0] static_of(input analog_ctrl_t a);
        return {a.muxInput, a.refFromDrivers, a.touchIrqEnable, a.eightBitMode};
    endfunction

    task automatic fail_msg(input string m);
        errors++;
        $display("ERROR at %0t ns: %s", $time, m);
    endtask

    task automatic check_static(input logic [7:0] cw);
        num_checks++;
        if (static_of(analogCtrl) !== static_of(settle_ctrl(cw))) fail_msg("word fields wrong");
    endtask

    task automatic check_final(input logic [7:0] cw);
        analog_ctrl_t e;
        e = settle_ctrl(cw);
        num_checks++;
        if (analogCtrl !== e) fail_msg("idle settings wrong");
        num_checks++;
        if (touchIrqOutN !== !(penTouched && e.touchIrqEnable)) fail_msg("pen interrupt wrong");
        num_checks++;
        if (conversionActive !== 1'b0) fail_msg("conversion still active");
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Waits for every noted word to show, then for the settings to go idle
    task automatic drain(input logic [7:0] cw);
        for (int t = 0; t < 300 && noteQ.size() != 0; t++) @(posedge core_clk);
        num_checks++;
        if (noteQ.size() != 0) fail_msg("word never took effect");
        noteQ.delete();
        repeat (20) @(posedge core_clk);
        #1 check_final(cw);
    endtask

    // Monitor: each change of the word fields consumes the oldest note
    always @(posedge core_clk) begin
        prevStatic <= static_of(analogCtrl);
        if (watch && prevStatic !== static_of(analogCtrl)) begin
            if (noteQ.size() == 0) begin
                fail_msg("settings changed without a word");
            end else begin
                check_static(noteQ.pop_front());
            end
        end
    end

    initial begin
        #300000;
        fail_msg("watchdog expired");
        finish_test();
    end

    initial begin
        rst = 1'b1;
        penTouched = 1'b0;
        watch = 1'b0;
        errors = 0;
        num_checks = 0;
        seed = 9;
        repeat (4) @(posedge core_clk);
        #1 rst = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 check_final(8'h00);
        watch = 1'b1;
        for (int c = 0; c < 6; c++) begin
            for (int p = 0; p < 4; p++) begin
                @(posedge core_clk);
                #1 penTouched = 1'($random(seed));
                w = {1'b1, chanTab[c], 1'($random(seed)), refTab[c], 2'(p)};
                noteQ.push_back(w);
                i_host_serial_model.send_word(w, {$random(seed)} % 4, 120);
                drain(w);
            end
        end
        // Next start on the first edge after the lockout, both resolutions
        for (int k = 0; k < 2; k++) begin
            w = {1'b1, CHAN_IN3, 1'(k), 1'b1, 2'h2};
            w2 = {1'b1, CHAN_YPLUS, 1'b0, 1'b0, 2'h3};
            noteQ.push_back(w);
            noteQ.push_back(w2);
            i_host_serial_model.send_word(w, 0, k ? 3 : 7);
            i_host_serial_model.send_word(w2, 0, 120);
            drain(w2);
        end
        finish_test();
    end
endmodule
`default_nettype wire
